// >>> hdl/vvs_pkg.sv
// Constants shared by the vector shift trip logic and its cycle timers.
// Assumes one 10 MHz system clock and a 50 Hz nominal network.
package vvs_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int NOMINAL_HZ = 50;
   localparam int NOM_PERIOD_CYCLES = CLK_HZ / NOMINAL_HZ;
   localparam int FREQ_DEV_PCT = 5;
   localparam int TRIP_PULSE_MS = 100;
   localparam int TRIP_PULSE_CYCLES = (CLK_HZ / 1000) * TRIP_PULSE_MS;
   localparam int PULSE_W = 20;

   // ****************************************************************
   // Data widths
   // ****************************************************************
   localparam int SAMPLE_W = 16;
   localparam int CNT_W = 18;
   localparam int ANGLE_W = 12;
   localparam int MAG_W = 10;
   localparam int LEVEL_W = 8;
   localparam int PICKUP_W = 9;
   localparam int NUM_SIG = 4;
   localparam int POS_IDX = 3;

   // ****************************************************************
   // Frequency band, in system clock ticks per cycle
   // ****************************************************************
   localparam logic [CNT_W-1:0] PERIOD_MIN = CNT_W'(NOM_PERIOD_CYCLES * (100 - FREQ_DEV_PCT) / 100);
   localparam logic [CNT_W-1:0] PERIOD_MAX = CNT_W'(NOM_PERIOD_CYCLES * (100 + FREQ_DEV_PCT) / 100);
   localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

   // ****************************************************************
   // Angle arithmetic, tenths of a degree
   // ****************************************************************
   localparam logic [31:0] FULL_TURN_TENTHS = 32'h00000E10;
   localparam logic [31:0] HALF_TURN_TENTHS = 32'h00000708;

   // ****************************************************************
   // Settings: encodings, defaults and ranges
   // ****************************************************************
   localparam logic [PICKUP_W-1:0] PICKUP_DEFAULT = 9'h03C;
   localparam logic [PICKUP_W-1:0] PICKUP_MIN = 9'h014;
   localparam logic [PICKUP_W-1:0] PICKUP_MAX = 9'h12C;
   localparam logic [LEVEL_W-1:0] OV_DEFAULT = 8'h78;
   localparam logic [LEVEL_W-1:0] OV_MIN = 8'h28;
   localparam logic [LEVEL_W-1:0] OV_MAX = 8'h96;
   localparam logic [LEVEL_W-1:0] UV_DEFAULT = 8'h50;
   localparam logic [LEVEL_W-1:0] UV_MIN = 8'h0F;
   localparam logic [LEVEL_W-1:0] UV_MAX = 8'h64;
   localparam logic [2:0] OP_ENABLE = 3'h1;
   localparam logic [2:0] OP_DISABLE = 3'h5;
   localparam logic [3:0] SUP_ALL = 4'h7;
   localparam logic [3:0] SUP_POS = 4'h8;
   localparam logic [NUM_SIG-1:0] MASK_ALL = 4'h7;
   localparam logic [NUM_SIG-1:0] MASK_POS = 4'h8;
   localparam logic VSEL_PH_GND = 1'b0;
   localparam logic VSEL_PH_PH = 1'b1;
   localparam logic VSEL_DEFAULT = 1'b0;

   // Phase-to-ground magnitude times sqrt(3), as 443/256
   localparam logic [8:0] PG_SCALE = 9'h1BB;
   localparam int PG_SHIFT = 8;

   // Status codes shown on the status port
   localparam logic [2:0] STAT_ENABLED = 3'h1;
   localparam logic [2:0] STAT_BLOCKED = 3'h2;
   localparam logic [2:0] STAT_DISABLED = 3'h5;

endpackage

// >>> hdl/vvs_cycle_timer.sv
// One cycle timer: times one voltage signal between positive zero crossings.
// Assumes samples and their strobe come from logic on the same clock.
`timescale 1ns/1ns
module vvs_cycle_timer (
   input wire logic clk,
   input wire logic nrst,
   input wire logic clear,
   input wire logic sampleValid,
   input wire logic signed [vvs_pkg::SAMPLE_W-1:0] sample,
   input wire logic [vvs_pkg::PICKUP_W-1:0] pickup,
   output logic newCycle,
   output logic hasRef,
   output logic [vvs_pkg::CNT_W-1:0] period,
   output logic signed [vvs_pkg::ANGLE_W-1:0] angle,
   output logic exceeds
);

   // ****************************************************************
   // Crossing detection and tick count
   // ****************************************************************
   logic prevNeg_reg;
   logic armed_reg;
   logic havePeriod_reg;
   logic [vvs_pkg::CNT_W-1:0] tickCnt_reg;
   logic crossing;
   logic signed [vvs_pkg::CNT_W:0] diff;
   logic [vvs_pkg::CNT_W:0] diffMag;
   logic [31:0] product;
   logic [31:0] quotient;
   logic [vvs_pkg::ANGLE_W-1:0] degMag;

   assign crossing = sampleValid && prevNeg_reg && !sample[vvs_pkg::SAMPLE_W-1];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prevNeg_reg <= 1'b0;
      end else if (clear) begin
         prevNeg_reg <= 1'b0;
      end else if (sampleValid) begin
         prevNeg_reg <= sample[vvs_pkg::SAMPLE_W-1];
      end
   end

   // Saturating count, so a stalled signal cannot wrap into a plausible period
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tickCnt_reg <= 18'h00001;
      end else if (clear || crossing) begin
         tickCnt_reg <= 18'h00001;
      end else if (tickCnt_reg != vvs_pkg::CNT_MAX) begin
         tickCnt_reg <= tickCnt_reg + 18'h00001;
      end
   end

   // ****************************************************************
   // Cycle comparison against the previous cycle
   // ****************************************************************
   always_comb begin
      diff = $signed({1'b0, period}) - $signed({1'b0, tickCnt_reg});
      diffMag = diff[vvs_pkg::CNT_W] ? 19'(-diff) : 19'(diff);
      product = 32'(diffMag) * vvs_pkg::FULL_TURN_TENTHS;
      quotient = product / 32'(period);
      degMag = (quotient > vvs_pkg::HALF_TURN_TENTHS) ? vvs_pkg::HALF_TURN_TENTHS[vvs_pkg::ANGLE_W-1:0]
                                                       : quotient[vvs_pkg::ANGLE_W-1:0];
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         armed_reg <= 1'b0;
         havePeriod_reg <= 1'b0;
         period <= 18'h00001;
         hasRef <= 1'b0;
      end else if (clear) begin
         armed_reg <= 1'b0;
         havePeriod_reg <= 1'b0;
         hasRef <= 1'b0;
      end else if (crossing) begin
         armed_reg <= 1'b1;
         if (armed_reg) begin
            period <= tickCnt_reg;
            havePeriod_reg <= 1'b1;
            hasRef <= havePeriod_reg;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         newCycle <= 1'b0;
         angle <= 12'h000;
         exceeds <= 1'b0;
      end else begin
         newCycle <= crossing && armed_reg && havePeriod_reg && !clear;
         if (clear) begin
            angle <= 12'h000;
            exceeds <= 1'b0;
         end else if (crossing && armed_reg && havePeriod_reg) begin
            // Shorter cycle than the reference reads as a positive step
            angle <= diff[vvs_pkg::CNT_W] ? -$signed(degMag) : $signed(degMag);
            exceeds <= degMag > 12'(pickup);
         end
      end
   end

endmodule

// >>> hdl/vvs_vector_shift_trip.sv
// Vector shift loss-of-mains trip: cycle timers, blocking and trip pulse.
// Assumes the front end delivers samples and magnitudes on the same clock.
`timescale 1ns/1ns
module vvs_vector_shift_trip #(
   parameter int TRIP_PULSE_CYCLES = vvs_pkg::TRIP_PULSE_CYCLES,
   parameter int NOM_PERIOD_CYCLES = vvs_pkg::NOM_PERIOD_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sampleValid,
   input wire logic signed [vvs_pkg::SAMPLE_W-1:0] voltageInPhaseOne,
   input wire logic signed [vvs_pkg::SAMPLE_W-1:0] voltageInPhaseTwo,
   input wire logic signed [vvs_pkg::SAMPLE_W-1:0] voltageInPhaseThree,
   input wire logic signed [vvs_pkg::SAMPLE_W-1:0] voltageInPosSeq,
   input wire logic [vvs_pkg::MAG_W-1:0] magPhaseOne,
   input wire logic [vvs_pkg::MAG_W-1:0] magPhaseTwo,
   input wire logic [vvs_pkg::MAG_W-1:0] magPhaseThree,
   input wire logic [vvs_pkg::MAG_W-1:0] magPosSeq,
   input wire logic blockIn,
   input wire logic settingLoad,
   input wire logic [vvs_pkg::PICKUP_W-1:0] pickupSetting,
   input wire logic [vvs_pkg::LEVEL_W-1:0] overVoltBlkSetting,
   input wire logic [vvs_pkg::LEVEL_W-1:0] underVoltBlkSetting,
   input wire logic [2:0] operationSetting,
   input wire logic [3:0] phaseSupervisionSetting,
   input wire logic voltageSelectionSetting,
   output logic trip,
   output logic internalBlockFlag,
   output logic lowAmplitudeBlockFlag,
   output logic signed [vvs_pkg::ANGLE_W-1:0] shiftAnglePhaseOne,
   output logic signed [vvs_pkg::ANGLE_W-1:0] shiftAnglePhaseTwo,
   output logic signed [vvs_pkg::ANGLE_W-1:0] shiftAnglePhaseThree,
   output logic signed [vvs_pkg::ANGLE_W-1:0] shiftAnglePositiveSeq,
   output logic [2:0] functionStatus
);

   // ****************************************************************
   // Settings
   // ****************************************************************
   logic [vvs_pkg::PICKUP_W-1:0] pickup_reg;
   logic [vvs_pkg::LEVEL_W-1:0] overVolt_reg;
   logic [vvs_pkg::LEVEL_W-1:0] underVolt_reg;
   logic [2:0] operation_reg;
   logic [3:0] supervision_reg;
   logic voltSel_reg;
   logic enabled;
   logic [vvs_pkg::NUM_SIG-1:0] supMask;

   // Out-of-range values are clamped so a bad write cannot make the function deaf
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pickup_reg <= vvs_pkg::PICKUP_DEFAULT;
         overVolt_reg <= vvs_pkg::OV_DEFAULT;
         underVolt_reg <= vvs_pkg::UV_DEFAULT;
      end else if (settingLoad) begin
         pickup_reg <= (pickupSetting < vvs_pkg::PICKUP_MIN) ? vvs_pkg::PICKUP_MIN :
                       (pickupSetting > vvs_pkg::PICKUP_MAX) ? vvs_pkg::PICKUP_MAX : pickupSetting;
         overVolt_reg <= (overVoltBlkSetting < vvs_pkg::OV_MIN) ? vvs_pkg::OV_MIN :
                         (overVoltBlkSetting > vvs_pkg::OV_MAX) ? vvs_pkg::OV_MAX : overVoltBlkSetting;
         underVolt_reg <= (underVoltBlkSetting < vvs_pkg::UV_MIN) ? vvs_pkg::UV_MIN :
                          (underVoltBlkSetting > vvs_pkg::UV_MAX) ? vvs_pkg::UV_MAX : underVoltBlkSetting;
      end
   end

   // Unknown codes are ignored and keep the previous choice
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         operation_reg <= vvs_pkg::OP_ENABLE;
         supervision_reg <= vvs_pkg::SUP_POS;
         voltSel_reg <= vvs_pkg::VSEL_DEFAULT;
      end else if (settingLoad) begin
         if (operationSetting == vvs_pkg::OP_ENABLE || operationSetting == vvs_pkg::OP_DISABLE) begin
            operation_reg <= operationSetting;
         end
         if (phaseSupervisionSetting == vvs_pkg::SUP_ALL || phaseSupervisionSetting == vvs_pkg::SUP_POS) begin
            supervision_reg <= phaseSupervisionSetting;
         end
         voltSel_reg <= voltageSelectionSetting;
      end
   end

   assign enabled = (operation_reg == vvs_pkg::OP_ENABLE);
   assign supMask = (supervision_reg == vvs_pkg::SUP_ALL) ? vvs_pkg::MASK_ALL : vvs_pkg::MASK_POS;

   // ****************************************************************
   // Cycle timers, one per signal
   // ****************************************************************
   logic signed [vvs_pkg::SAMPLE_W-1:0] sampleArr [vvs_pkg::NUM_SIG];
   logic [vvs_pkg::MAG_W-1:0] magArr [vvs_pkg::NUM_SIG];
   logic signed [vvs_pkg::ANGLE_W-1:0] angleArr [vvs_pkg::NUM_SIG];
   logic [vvs_pkg::CNT_W-1:0] periodArr [vvs_pkg::NUM_SIG];
   logic [vvs_pkg::NUM_SIG-1:0] newCycleVec;
   logic [vvs_pkg::NUM_SIG-1:0] hasRefVec;
   logic [vvs_pkg::NUM_SIG-1:0] exceedsVec;
   logic [vvs_pkg::NUM_SIG-1:0] uvHit;
   logic [vvs_pkg::NUM_SIG-1:0] ovHit;
   logic [vvs_pkg::NUM_SIG-1:0] freqBad;
   logic timerClear;
   logic intBlkNow;
   logic lowAmplNow;

   // Band follows the nominal period, so a shortened nominal keeps the same percentage
   localparam int BAND_LO = NOM_PERIOD_CYCLES * (100 - vvs_pkg::FREQ_DEV_PCT) / 100;
   localparam int BAND_HI = NOM_PERIOD_CYCLES * (100 + vvs_pkg::FREQ_DEV_PCT) / 100;
   localparam logic [vvs_pkg::CNT_W-1:0] PERIOD_LO = BAND_LO[vvs_pkg::CNT_W-1:0];
   localparam logic [vvs_pkg::CNT_W-1:0] PERIOD_HI = BAND_HI[vvs_pkg::CNT_W-1:0];

   assign sampleArr[0] = voltageInPhaseOne;
   assign sampleArr[1] = voltageInPhaseTwo;
   assign sampleArr[2] = voltageInPhaseThree;
   assign sampleArr[vvs_pkg::POS_IDX] = voltageInPosSeq;
   assign magArr[0] = magPhaseOne;
   assign magArr[1] = magPhaseTwo;
   assign magArr[2] = magPhaseThree;
   assign magArr[vvs_pkg::POS_IDX] = magPosSeq;

   // Timing restarts from scratch after blockIn, disable or an internal block; the frequency band block does not clear it
   assign timerClear = blockIn || !enabled || intBlkNow;

   genvar gi;
   generate
      for (gi = 0; gi < vvs_pkg::NUM_SIG; gi++) begin : gSig
         logic [18:0] scaledWide;
         logic [10:0] magPu;

         vvs_cycle_timer uTimer (
            .clk(clk),
            .nrst(nrst),
            .clear(timerClear),
            .sampleValid(sampleValid),
            .sample(sampleArr[gi]),
            .pickup(pickup_reg),
            .newCycle(newCycleVec[gi]),
            .hasRef(hasRefVec[gi]),
            .period(periodArr[gi]),
            .angle(angleArr[gi]),
            .exceeds(exceedsVec[gi])
         );

         // Phase-to-ground magnitudes are raised by sqrt(3) to the per-unit base
         assign scaledWide = 19'(magArr[gi]) * 19'(vvs_pkg::PG_SCALE);
         assign magPu = (voltSel_reg == vvs_pkg::VSEL_PH_GND) ? 11'(scaledWide >> vvs_pkg::PG_SHIFT)
                                                              : 11'(magArr[gi]);
         assign uvHit[gi] = magPu < 11'(underVolt_reg);
         assign ovHit[gi] = magPu > 11'(overVolt_reg);
         assign freqBad[gi] = hasRefVec[gi] &&
                              (periodArr[gi] < PERIOD_LO || periodArr[gi] > PERIOD_HI);
      end
   endgenerate

   assign intBlkNow = enabled && !blockIn && ((supMask & (uvHit | ovHit)) != 4'h0);
   assign lowAmplNow = enabled && !blockIn && ((supMask & freqBad) != 4'h0);

   // ****************************************************************
   // Detection flags, held until the signal's next cycle, a timer clear or a trip start that consumes them
   // ****************************************************************
   logic [vvs_pkg::NUM_SIG-1:0] exceedFlag_reg;
   logic allExceed;
   logic tripStart;
   logic pulseRunning;
   logic [vvs_pkg::PULSE_W-1:0] pulseCnt_reg;

   assign allExceed = ((exceedFlag_reg & supMask) == supMask);
   assign pulseRunning = trip;
   assign tripStart = allExceed && enabled && !blockIn && !intBlkNow && !lowAmplNow && !pulseRunning;

   // A fresh result in the same cycle as consumption wins over the clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         exceedFlag_reg <= 4'h0;
      end else if (timerClear) begin
         exceedFlag_reg <= 4'h0;
      end else begin
         for (int i = 0; i < vvs_pkg::NUM_SIG; i++) begin
            if (newCycleVec[i]) begin
               exceedFlag_reg[i] <= exceedsVec[i];
            end else if (tripStart) begin
               exceedFlag_reg[i] <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // Trip pulse
   // ****************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         trip <= 1'b0;
         pulseCnt_reg <= 20'h00000;
      end else if (blockIn || !enabled) begin
         trip <= 1'b0;
         pulseCnt_reg <= 20'h00000;
      end else if (tripStart) begin
         trip <= 1'b1;
         pulseCnt_reg <= vvs_pkg::PULSE_W'(TRIP_PULSE_CYCLES - 1);
      end else if (trip) begin
         // Fixed length: later detections do not restart the count
         if (pulseCnt_reg == 20'h00000) begin
            trip <= 1'b0;
         end else begin
            pulseCnt_reg <= pulseCnt_reg - 20'h00001;
         end
      end
   end

   // ****************************************************************
   // Block flags and status
   // ****************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         internalBlockFlag <= 1'b0;
         lowAmplitudeBlockFlag <= 1'b0;
      end else begin
         internalBlockFlag <= intBlkNow;
         lowAmplitudeBlockFlag <= lowAmplNow;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         functionStatus <= vvs_pkg::STAT_ENABLED;
      end else if (!enabled) begin
         functionStatus <= vvs_pkg::STAT_DISABLED;
      end else if (blockIn) begin
         functionStatus <= vvs_pkg::STAT_BLOCKED;
      end else begin
         functionStatus <= vvs_pkg::STAT_ENABLED;
      end
   end

   // ****************************************************************
   // Angles of the latest trip
   // ****************************************************************
   // Kept across block and disable so the cause of the last trip stays readable
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shiftAnglePhaseOne <= 12'h000;
         shiftAnglePhaseTwo <= 12'h000;
         shiftAnglePhaseThree <= 12'h000;
         shiftAnglePositiveSeq <= 12'h000;
      end else if (tripStart) begin
         shiftAnglePhaseOne <= supMask[0] ? angleArr[0] : 12'h000;
         shiftAnglePhaseTwo <= supMask[1] ? angleArr[1] : 12'h000;
         shiftAnglePhaseThree <= supMask[2] ? angleArr[2] : 12'h000;
         shiftAnglePositiveSeq <= supMask[vvs_pkg::POS_IDX] ? angleArr[vvs_pkg::POS_IDX] : 12'h000;
      end
   end

endmodule

// >>> test/vvs_vector_shift_trip_asserts.sv
// Port checker for the vector shift trip block.
// Assumes a bind onto the top module, one clock, reset active low.
`timescale 1ns/1ns
module vvs_vector_shift_trip_asserts #(
   parameter int TRIP_PULSE_CYCLES = 20
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic blockIn,
   input wire logic settingLoad,
   input wire logic [2:0] operationSetting,
   input wire logic trip,
   input wire logic internalBlockFlag,
   input wire logic lowAmplitudeBlockFlag,
   input wire logic signed [vvs_pkg::ANGLE_W-1:0] shiftAnglePositiveSeq,
   input wire logic [2:0] functionStatus
);
   // ****************************************
   // Trip length counter and properties
   // ****************************************
   // Counter avoids a long repetition that the tools would unroll
   int tripCnt_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) tripCnt_reg <= 0;
      else tripCnt_reg <= trip ? tripCnt_reg + 1 : 0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // A disable load cuts the pulse one cycle after the load is taken
   property p_trip_len;
      $fell(trip) |-> tripCnt_reg == TRIP_PULSE_CYCLES || $past(blockIn) || $past(settingLoad, 2);
   endproperty
   a_trip_len: assert property (p_trip_len) else $error("trip pulse length wrong");
   property p_blk_out; blockIn |=> !trip && !internalBlockFlag && !lowAmplitudeBlockFlag; endproperty
   a_blk_out: assert property (p_blk_out) else $error("outputs not cleared by block");
   // Disabled status outranks blocked, so block is judged only while not disabled
   property p_blk_stat;
      blockIn && functionStatus != vvs_pkg::STAT_DISABLED && !settingLoad && !$past(settingLoad)
         |=> functionStatus == vvs_pkg::STAT_BLOCKED;
   endproperty
   a_blk_stat: assert property (p_blk_stat) else $error("status not blocked");
   property p_dis_quiet; functionStatus == vvs_pkg::STAT_DISABLED |-> !trip; endproperty
   a_dis_quiet: assert property (p_dis_quiet) else $error("trip while disabled");
   property p_op_load;
      settingLoad && operationSetting == vvs_pkg::OP_DISABLE |-> ##[1:2] functionStatus == vvs_pkg::STAT_DISABLED;
   endproperty
   a_op_load: assert property (p_op_load) else $error("disable code not taken");
   property p_trip_cause;
      $rose(trip) |-> !$past(blockIn) && !$past(internalBlockFlag) && !$past(lowAmplitudeBlockFlag);
   endproperty
   a_trip_cause: assert property (p_trip_cause) else $error("trip started while blocked");
   property p_ang_hold; !$rose(trip) |-> $stable(shiftAnglePositiveSeq); endproperty
   a_ang_hold: assert property (p_ang_hold) else $error("monitored angle changed without trip");
   property p_ang_rng; shiftAnglePositiveSeq <= 12'sh708 && shiftAnglePositiveSeq >= -12'sh708; endproperty
   a_ang_rng: assert property (p_ang_rng) else $error("angle out of range");
endmodule
bind vvs_vector_shift_trip vvs_vector_shift_trip_asserts #(.TRIP_PULSE_CYCLES(TRIP_PULSE_CYCLES)) u_chk (
   .clk(clk), .nrst(nrst), .blockIn(blockIn), .settingLoad(settingLoad), .operationSetting(operationSetting),
   .trip(trip), .internalBlockFlag(internalBlockFlag), .lowAmplitudeBlockFlag(lowAmplitudeBlockFlag),
   .shiftAnglePositiveSeq(shiftAnglePositiveSeq), .functionStatus(functionStatus));

// >>> test/vvs_front_end_model.sv
// Front end model: square-wave samples with a settable cycle length.
// Assumes the bench changes cycleLen at most once per cycle.
`timescale 1ns/1ns
module vvs_front_end_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [vvs_pkg::CNT_W-1:0] cycleLen,
   output logic sampleValid,
   output logic signed [vvs_pkg::SAMPLE_W-1:0] sample,
   output logic crossing
);
   // ****************************************
   // Waveform
   // ****************************************
   logic [vvs_pkg::CNT_W-1:0] cnt_reg, len_reg;
   // Length taken only at cycle end, so no cycle is cut short
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= 18'h0;
         len_reg <= 18'h007D0;
      end else if (cnt_reg >= len_reg - 18'h1) begin
         cnt_reg <= 18'h0;
         len_reg <= cycleLen;
      end else begin
         cnt_reg <= cnt_reg + 18'h1;
      end
   end
   assign sampleValid = nrst;
   assign sample = (cnt_reg < (len_reg >> 1)) ? 16'sh2000 : 16'shE000;
   assign crossing = cnt_reg == 18'h0;
endmodule

// >>> test/vvs_vector_shift_trip_tb_top.sv
// Bench for the vector shift trip: settings, blocking, trips, band check.
// Assumes the front end model drives all four sample inputs.
`timescale 1ns/1ns
module vvs_vector_shift_trip_tb_top;
   // ****************************************
   // Signals, tasks and sequence
   // ****************************************
   localparam int TRIP_N = 20;
   // Short nominal cycle keeps the run brief; angles scale the same
   localparam int NOM_N = 2000;
   logic clk = 1'b0, nrst = 1'b0, blockIn = 1'b0, settingLoad = 1'b0;
   logic sampleValid, crossing, trip, intBlk, lowAmpl;
   logic signed [vvs_pkg::SAMPLE_W-1:0] sample;
   logic [vvs_pkg::CNT_W-1:0] cycleLen = 18'h007D0;
   logic [vvs_pkg::MAG_W-1:0] magOne = 10'h03A, magPos = 10'h03A;
   logic [2:0] opSet = vvs_pkg::OP_ENABLE, status;
   logic [3:0] supSet = vvs_pkg::SUP_POS;
   logic vselSet = vvs_pkg::VSEL_DEFAULT;
   logic signed [vvs_pkg::ANGLE_W-1:0] angOne, angTwo, angThree, angPos;
   int n_mismatch = 0, cmp_count = 0;
   initial forever #50 clk = ~clk;
   vvs_front_end_model u_fe (.clk(clk), .nrst(nrst), .cycleLen(cycleLen), .sampleValid(sampleValid),
      .sample(sample), .crossing(crossing));
   vvs_vector_shift_trip #(.TRIP_PULSE_CYCLES(TRIP_N), .NOM_PERIOD_CYCLES(NOM_N)) DUT (.clk(clk), .nrst(nrst),
      .sampleValid(sampleValid),
      .voltageInPhaseOne(sample), .voltageInPhaseTwo(sample), .voltageInPhaseThree(sample),
      .voltageInPosSeq(sample), .magPhaseOne(magOne), .magPhaseTwo(10'h03A), .magPhaseThree(10'h03A),
      .magPosSeq(magPos), .blockIn(blockIn), .settingLoad(settingLoad), .pickupSetting(vvs_pkg::PICKUP_DEFAULT),
      .overVoltBlkSetting(vvs_pkg::OV_DEFAULT), .underVoltBlkSetting(vvs_pkg::UV_DEFAULT),
      .operationSetting(opSet), .phaseSupervisionSetting(supSet), .voltageSelectionSetting(vselSet),
      .trip(trip), .internalBlockFlag(intBlk), .lowAmplitudeBlockFlag(lowAmpl), .shiftAnglePhaseOne(angOne),
      .shiftAnglePhaseTwo(angTwo), .shiftAnglePhaseThree(angThree), .shiftAnglePositiveSeq(angPos),
      .functionStatus(status));
   task automatic test_done();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic setBlk(input logic b);
      @(posedge clk);
      blockIn <= b;
      cyc(1);
   endtask
   task automatic setMag(input logic [9:0] one, input logic [9:0] pos);
      @(posedge clk);
      magOne <= one;
      magPos <= pos;
      cyc(2);
   endtask
   task automatic load(input logic [2:0] op, input logic [3:0] sup, input logic vsel);
      @(posedge clk);
      settingLoad <= 1'b1;
      opSet <= op;
      supSet <= sup;
      vselSet <= vsel;
      @(posedge clk);
      settingLoad <= 1'b0;
      cyc(3);
   endtask
   // Bound covers one full nominal cycle with margin
   task automatic waitCross();
      int i;
      for (i = 0; i < 3000; i++) begin
         @(posedge clk);
         #10;
         if (crossing === 1'b1) break;
      end
      if (i == 3000) begin
         n_mismatch++;
         test_done();
      end
   endtask
   task automatic chkTrip(input logic [11:0] ang);
      cyc(2);
      chk(trip, 12'h0);
      cyc(1);
      chk(trip, 12'h1);
      chk(angPos, ang);
      chk(angOne, 12'h0);
      chk(angTwo, 12'h0);
      chk(angThree, 12'h0);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      cyc(1);
      chk(trip, 12'h0);
      chk(status, 12'h1);
      $display("Test reset done");
      setBlk(1'b1);
      chk(status, 12'h2);
      setBlk(1'b0);
      cyc(1);
      chk(status, 12'h1);
      setMag(10'h03A, 10'h028);
      chk(intBlk, 12'h1);
      setMag(10'h028, 10'h03A);
      chk(intBlk, 12'h0);
      load(vvs_pkg::OP_ENABLE, vvs_pkg::SUP_ALL, vvs_pkg::VSEL_PH_GND);
      chk(intBlk, 12'h1);
      setMag(10'h03A, 10'h03A);
      chk(intBlk, 12'h0);
      load(vvs_pkg::OP_ENABLE, vvs_pkg::SUP_POS, vvs_pkg::VSEL_PH_PH);
      chk(intBlk, 12'h1);
      load(vvs_pkg::OP_ENABLE, vvs_pkg::SUP_POS, vvs_pkg::VSEL_PH_GND);
      setMag(10'h03A, 10'h050);
      chk(intBlk, 12'h1);
      setMag(10'h03A, 10'h03A);
      $display("Test magnitude block done");
      load(vvs_pkg::OP_DISABLE, vvs_pkg::SUP_POS, vvs_pkg::VSEL_PH_GND);
      chk(status, 12'h5);
      load(3'h3, vvs_pkg::SUP_POS, vvs_pkg::VSEL_PH_GND);
      chk(status, 12'h5);
      load(vvs_pkg::OP_ENABLE, vvs_pkg::SUP_POS, vvs_pkg::VSEL_PH_GND);
      chk(status, 12'h1);
      $display("Test operation done");
      waitCross();
      cycleLen <= 18'h007A8;
      waitCross();
      cycleLen <= 18'h00780;
      waitCross();
      cycleLen <= 18'h00708;
      chkTrip(12'h048);
      cyc(TRIP_N - 1);
      chk(trip, 12'h1);
      cyc(1);
      chk(trip, 12'h0);
      $display("Test first trip done");
      waitCross();
      chkTrip(12'h049);
      cyc(4);
      setBlk(1'b1);
      chk(trip, 12'h0);
      chk(angPos, 12'h049);
      setBlk(1'b0);
      $display("Test block in pulse done");
      // Third fresh crossing is the first with a reference, so the band check starts there
      waitCross();
      waitCross();
      waitCross();
      cyc(4);
      chk(lowAmpl, 12'h1);
      $display("Test frequency band done");
      test_done();
   end
endmodule
